// ### hdl/acfc_pkg.sv
/*
 * acfc_pkg: constants and types of the command frame codec.
 * Assumes one clock, unescaped byte stream, frame offsets counted from the delimiter at 0.
 */
// Function
// - remote command request carries frame type 0x17 at offset 3
// - correlation id at offset 4; zero id suppresses any response frame
// - options at offset 15; 0x02 means apply now, other bits zero
// - remote write without apply stays pending until apply-changes command
// - command name at 16..17, parameter bytes follow before checksum
// - each local command 0x08/0x09 is answered by a 0x88 response
// - some commands, like node discovery, yield several response frames
// - response echoes id at offset 4 and command name at 5..6
// - status at offset 7: 0 ok, 1 error, 2 unknown, 3 bad parameter
// - queried value from offset 8 on; omitted when the command wrote
// - status notification has type 0x8A and status code at offset 4
// - after power-up one status notification with code 0x00 is sent
// - checksum is 0xFF minus low byte of sum from type to payload
package acfc_pkg;
	localparam logic [7:0]  DELIM       = 8'h7E;
	localparam logic [7:0]  FT_LCMD     = 8'h08;
	localparam logic [7:0]  FT_LCMDQ    = 8'h09;
	localparam logic [7:0]  FT_RCMD     = 8'h17;
	localparam logic [7:0]  FT_LRSP     = 8'h88;
	localparam logic [7:0]  FT_STAT     = 8'h8A;
	localparam logic [7:0]  CSUM_OK     = 8'hFF;
	localparam logic [7:0]  OPT_APPLY   = 8'h02;
	localparam logic [7:0]  STAT_PWRUP  = 8'h00;
	localparam logic [7:0]  ID_NONE     = 8'h00;
	localparam logic [7:0]  ST_OK       = 8'h00;
	localparam logic [7:0]  ST_ERROR    = 8'h01;
	localparam logic [7:0]  ST_BADCMD   = 8'h02;
	localparam logic [7:0]  ST_BADPAR   = 8'h03;
	localparam logic [15:0] NAME_APPLY  = 16'h4143; // ascii of the apply-changes command
	// frame offsets, delimiter at 0
	localparam logic [15:0] OFS_TYPE    = 16'h0003;
	localparam logic [15:0] OFS_ID      = 16'h0004;
	localparam logic [15:0] OFS_L_NAME  = 16'h0005;
	localparam logic [15:0] OFS_L_PARAM = 16'h0007;
	localparam logic [15:0] OFS_R_ADDR  = 16'h0005;
	localparam logic [15:0] OFS_R_ADDRL = 16'h000C;
	localparam logic [15:0] OFS_R_OPT   = 16'h000F;
	localparam logic [15:0] OFS_R_NAME  = 16'h0010;
	localparam logic [15:0] OFS_R_PARAM = 16'h0012;
	localparam logic [15:0] OFS_S_NAME  = 16'h0005;
	localparam logic [15:0] OFS_S_STAT  = 16'h0007;
	localparam logic [15:0] OFS_S_DATA  = 16'h0008;
	localparam logic [15:0] LEN_STAT    = 16'h0002;
	localparam logic [15:0] LEN_RSP     = 16'h0005;
	localparam logic [15:0] ONE         = 16'h0001;
	// parameter store and response data sizes
	localparam int          PMEM_AW     = 4;
	localparam logic [15:0] PMEM_DEPTH  = 16'h0010;
	localparam logic [3:0]  RSP_DMAX    = 4'h8;

	typedef enum logic [2:0] {
		RX_HUNT = 3'b000,
		RX_LENH = 3'b001,
		RX_LENL = 3'b010,
		RX_BODY = 3'b011,
		RX_CSUM = 3'b100,
		RX_HOLD = 3'b101
	} acfc_rx_state_type;

	typedef enum logic [2:0] {
		TX_IDLE = 3'b000,
		TX_DELM = 3'b001,
		TX_LENH = 3'b010,
		TX_LENL = 3'b011,
		TX_BODY = 3'b100,
		TX_CSUM = 3'b101
	} acfc_tx_state_type;
endpackage : acfc_pkg

// ### hdl/acfc_buf2.sv
/*
 * acfc_buf2: two-entry buffer with valid/ready on both sides.
 * Assumes a single clock; the drain side may stall freely.
 */
`timescale 1ns/1ps
module acfc_buf2 #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input  wire logic             mclk,
	input  wire logic             arst_n,
	// fill side
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	// drain side
	output logic [WIDTH-1:0]      out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	logic [WIDTH-1:0] mem_q [2];
	logic             wp_q;
	logic             rp_q;
	logic [1:0]       cnt_q;
	logic             push;
	logic             pop;

	// full and empty come straight from the count, never guessed
	assign in_ready  = (cnt_q != 2'b10);
	assign out_valid = (cnt_q != 2'b00);
	assign out_data  = mem_q[rp_q];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// storage
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			mem_q[0] <= '0;
			mem_q[1] <= '0;
		end else if (push) begin
			mem_q[wp_q] <= in_data;
		end
	end

	// pointers and count
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			wp_q  <= 1'b0;
			rp_q  <= 1'b0;
			cnt_q <= 2'b00;
		end else begin
			wp_q  <= wp_q ^ push;
			rp_q  <= rp_q ^ pop;
			cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule : acfc_buf2

// ### hdl/acfc_pmem.sv
/*
 * acfc_pmem: small parameter byte store, one write and one registered read port.
 * Assumes writer and reader share the clock.
 */
`timescale 1ns/1ps
module acfc_pmem (
	// clock and reset
	input  wire logic                       mclk,
	input  wire logic                       arst_n,
	// write port
	input  wire logic                       wr_en,
	input  wire logic [acfc_pkg::PMEM_AW-1:0] wr_addr,
	input  wire logic [7:0]                 wr_data,
	// read port
	input  wire logic [acfc_pkg::PMEM_AW-1:0] rd_addr,
	output logic [7:0]                      rd_data
);
	import acfc_pkg::*;

	logic [7:0] mem_q [2**PMEM_AW];

	// array write, no reset needed on contents
	always_ff @(posedge mclk) begin
		if (wr_en) begin
			mem_q[wr_addr] <= wr_data;
		end
	end

	// read data leaves from a flop, one cycle after the address
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rd_data <= 8'h00;
		end else begin
			rd_data <= mem_q[rd_addr];
		end
	end
endmodule : acfc_pmem

// ### hdl/acfc_codec.sv
/*
 * acfc_codec: parses command request frames from the host and builds
 * command response and status notification frames back to it.
 * Assumes an unescaped byte stream, synchronous inputs, one clock.
 */
`timescale 1ns/1ps
module acfc_codec (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        arst_n,
	// bytes from host
	input  wire logic [7:0]  rx_data,
	input  wire logic        rx_valid,
	output logic             rx_ready,
	// bytes to host
	output logic [7:0]       tx_data,
	output logic             tx_valid,
	input  wire logic        tx_ready,
	// decoded request
	output logic             req_valid,
	input  wire logic        req_ready,
	output logic             req_remote,
	output logic [7:0]       req_frame_id,
	output logic [15:0]      req_name,
	output logic [63:0]      req_addr,
	output logic             req_apply,
	output logic [15:0]      req_plen,
	input  wire logic [acfc_pkg::PMEM_AW-1:0] param_raddr,
	output logic [7:0]       param_rdata,
	output logic             remote_pending,
	output logic             rx_bad_frame,
	// response to send
	input  wire logic        rsp_valid,
	output logic             rsp_ready,
	input  wire logic [7:0]  rsp_frame_id,
	input  wire logic [15:0] rsp_name,
	input  wire logic [7:0]  rsp_status,
	input  wire logic [63:0] rsp_data,
	input  wire logic [3:0]  rsp_dlen,
	// status event
	input  wire logic        stat_valid,
	output logic             stat_ready,
	input  wire logic [7:0]  stat_code
);
	import acfc_pkg::*;

	acfc_rx_state_type rx_st_q;
	logic [15:0] rx_len_q;
	logic [15:0] rx_pos_q;
	logic [7:0]  rx_type_q;
	logic [7:0]  rx_sum_q;
	logic        rx_ovf_q;
	logic        rx_local;
	logic        rx_rmt;
	logic        rx_take;
	logic        rx_good;
	logic [15:0] rx_pbase;
	logic [15:0] rx_nbase;
	logic [15:0] rx_pidx;
	logic        pm_we;

	assign rx_take  = rx_valid && rx_ready;
	assign rx_ready = (rx_st_q != RX_HOLD); // back-pressure while a request waits
	assign rx_local = (rx_type_q == FT_LCMD) || (rx_type_q == FT_LCMDQ);
	assign rx_rmt   = (rx_type_q == FT_RCMD);
	assign rx_pbase = rx_rmt ? OFS_R_PARAM : OFS_L_PARAM;
	assign rx_nbase = rx_rmt ? OFS_R_NAME : OFS_L_NAME;
	assign rx_pidx  = rx_pos_q - rx_pbase;
	assign rx_good  = (8'(rx_sum_q + rx_data) == CSUM_OK);
	assign pm_we    = rx_take && (rx_st_q == RX_BODY) && (rx_local || rx_rmt)
	                  && (rx_pos_q >= rx_pbase) && (rx_pidx < PMEM_DEPTH);
	assign req_valid = (rx_st_q == RX_HOLD);

	// receive state: hunt delimiter, length MSB first, body, checksum
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rx_st_q <= RX_HUNT;
		end else begin
			case (rx_st_q)
				RX_HUNT: if (rx_take && rx_data == DELIM) rx_st_q <= RX_LENH;
				RX_LENH: if (rx_take) rx_st_q <= RX_LENL;
				RX_LENL: if (rx_take) rx_st_q <= ({rx_len_q[15:8], rx_data} == '0) ? RX_HUNT : RX_BODY;
				RX_BODY: if (rx_take && rx_pos_q == OFS_TYPE + rx_len_q - ONE) rx_st_q <= RX_CSUM;
				RX_CSUM: if (rx_take) begin
					// a bad sum or unsupported frame is dropped, hunt again
					rx_st_q <= (rx_good && !rx_ovf_q && (rx_local || rx_rmt)) ? RX_HOLD : RX_HUNT;
				end
				RX_HOLD: if (req_ready) rx_st_q <= RX_HUNT;
				default: rx_st_q <= RX_HUNT;
			endcase
		end
	end

	// length, position, running sum and overflow of the frame in flight
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rx_len_q <= 16'h0000;
			rx_pos_q <= 16'h0000;
			rx_sum_q <= 8'h00;
			rx_ovf_q <= 1'b0;
		end else if (rx_take) begin
			if (rx_st_q == RX_LENH) rx_len_q[15:8] <= rx_data;
			if (rx_st_q == RX_LENL) begin
				rx_len_q[7:0] <= rx_data;
				rx_pos_q      <= OFS_TYPE;
				rx_sum_q      <= 8'h00;
				rx_ovf_q      <= 1'b0;
			end
			if (rx_st_q == RX_BODY) begin
				rx_pos_q <= rx_pos_q + ONE;
				rx_sum_q <= rx_sum_q + rx_data;
				if (rx_pos_q >= rx_pbase && rx_pidx >= PMEM_DEPTH) rx_ovf_q <= 1'b1;
			end
		end
	end

	// field capture; the address is shifted in MSB first
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rx_type_q    <= 8'h00;
			req_frame_id <= 8'h00;
			req_name     <= 16'h0000;
			req_addr     <= '0;
			req_apply    <= 1'b0;
			req_plen     <= 16'h0000;
		end else if (rx_take && rx_st_q == RX_BODY) begin
			if (rx_pos_q == OFS_TYPE) begin
				rx_type_q <= rx_data;
				req_plen  <= 16'h0000;
				req_apply <= 1'b0;
			end
			if (rx_pos_q == OFS_ID) req_frame_id <= rx_data;
			if (rx_rmt && rx_pos_q >= OFS_R_ADDR && rx_pos_q <= OFS_R_ADDRL) begin
				req_addr <= {req_addr[55:0], rx_data};
			end
			// only the apply value counts; other option bits must be zero
			if (rx_rmt && rx_pos_q == OFS_R_OPT) req_apply <= (rx_data == OPT_APPLY);
			if (rx_pos_q == rx_nbase) req_name[15:8] <= rx_data;
			if (rx_pos_q == rx_nbase + ONE) req_name[7:0] <= rx_data;
			if (rx_pos_q >= rx_pbase && (rx_local || rx_rmt)) req_plen <= req_plen + ONE;
		end
	end

	assign req_remote = rx_rmt;

	// remote writes without apply stay pending until a remote apply-changes command or a remote request with the apply option
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			remote_pending <= 1'b0;
		end else if (req_valid && req_ready && rx_rmt) begin
			if (req_name == NAME_APPLY || req_apply) remote_pending <= 1'b0;
			else if (req_plen != 16'h0000) remote_pending <= 1'b1;
		end
	end

	// one-cycle pulse on a frame dropped for a bad checksum
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rx_bad_frame <= 1'b0;
		end else begin
			rx_bad_frame <= rx_take && rx_st_q == RX_CSUM && !rx_good;
		end
	end

	acfc_pmem u_pmem (
		.mclk    (mclk),
		.arst_n  (arst_n),
		.wr_en   (pm_we),
		.wr_addr (rx_pidx[PMEM_AW-1:0]),
		.wr_data (rx_data),
		.rd_addr (param_raddr),
		.rd_data (param_rdata)
	);

	// transmit side
	acfc_tx_state_type tx_st_q;
	logic        pwrup_q;
	logic        kstat_q;
	logic [7:0]  t_id_q;
	logic [15:0] t_name_q;
	logic [7:0]  t_code_q;
	logic [63:0] t_data_q;
	logic [15:0] t_len_q;
	logic [15:0] t_pos_q;
	logic [7:0]  t_sum_q;
	logic [7:0]  push_data;
	logic [7:0]  body_byte;
	logic        push_valid;
	logic        push_ready;
	logic        push;
	logic        go_stat;
	logic        go_rsp;
	logic [15:0] didx;

	assign push_valid = (tx_st_q != TX_IDLE);
	assign push       = push_valid && push_ready;
	// power-up notice first, then events, then responses
	assign go_stat    = (tx_st_q == TX_IDLE) && (pwrup_q || stat_valid);
	assign go_rsp     = (tx_st_q == TX_IDLE) && !pwrup_q && !stat_valid && rsp_valid;
	assign stat_ready = (tx_st_q == TX_IDLE) && !pwrup_q;
	// zero id is accepted and thrown away, so no frame goes out
	assign rsp_ready  = go_rsp;
	assign didx       = t_pos_q - OFS_S_DATA;

	// byte of the frame body at the current offset
	always_comb begin
		body_byte = 8'h00;
		if (t_pos_q == OFS_TYPE) body_byte = kstat_q ? FT_STAT : FT_LRSP;
		else if (t_pos_q == OFS_ID) body_byte = kstat_q ? t_code_q : t_id_q;
		else if (t_pos_q == OFS_S_NAME) body_byte = t_name_q[15:8];
		else if (t_pos_q == OFS_S_NAME + ONE) body_byte = t_name_q[7:0];
		else if (t_pos_q == OFS_S_STAT) body_byte = t_code_q;
		else body_byte = t_data_q[63 - 8 * didx[2:0] -: 8];
	end

	// byte handed to the buffer
	always_comb begin
		case (tx_st_q)
			TX_DELM: push_data = DELIM;
			TX_LENH: push_data = t_len_q[15:8];
			TX_LENL: push_data = t_len_q[7:0];
			TX_BODY: push_data = body_byte;
			TX_CSUM: push_data = CSUM_OK - t_sum_q;
			default: push_data = 8'h00;
		endcase
	end

	// frame builder sequence
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			tx_st_q <= TX_IDLE;
		end else begin
			case (tx_st_q)
				TX_IDLE: if (go_stat || (go_rsp && rsp_frame_id != ID_NONE)) tx_st_q <= TX_DELM;
				TX_DELM: if (push) tx_st_q <= TX_LENH;
				TX_LENH: if (push) tx_st_q <= TX_LENL;
				TX_LENL: if (push) tx_st_q <= TX_BODY;
				TX_BODY: if (push && t_pos_q == OFS_TYPE + t_len_q - ONE) tx_st_q <= TX_CSUM;
				TX_CSUM: if (push) tx_st_q <= TX_IDLE;
				default: tx_st_q <= TX_IDLE;
			endcase
		end
	end

	// latch the frame contents at launch; every response handshake with a nonzero id is one
	// frame, so a command answered in parts simply offers several
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pwrup_q  <= 1'b1;
			kstat_q  <= 1'b0;
			t_id_q   <= 8'h00;
			t_name_q <= 16'h0000;
			t_code_q <= 8'h00;
			t_data_q <= '0;
			t_len_q  <= 16'h0000;
		end else if (go_stat) begin
			pwrup_q  <= 1'b0;
			kstat_q  <= 1'b1;
			t_code_q <= pwrup_q ? STAT_PWRUP : stat_code;
			t_len_q  <= LEN_STAT;
		end else if (go_rsp) begin
			kstat_q  <= 1'b0;
			t_id_q   <= rsp_frame_id;
			t_name_q <= rsp_name;
			t_code_q <= rsp_status;
			t_data_q <= rsp_data;
			// write results carry no data; longer data is clipped
			t_len_q  <= LEN_RSP + {12'h000, (rsp_dlen > RSP_DMAX) ? RSP_DMAX : rsp_dlen};
		end
	end

	// position and running sum of the outgoing body
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			t_pos_q <= 16'h0000;
			t_sum_q <= 8'h00;
		end else if (push && tx_st_q == TX_LENL) begin
			t_pos_q <= OFS_TYPE;
			t_sum_q <= 8'h00;
		end else if (push && tx_st_q == TX_BODY) begin
			t_pos_q <= t_pos_q + ONE;
			t_sum_q <= t_sum_q + body_byte;
		end
	end

	// buffer so a stalled host loses nothing
	acfc_buf2 #(.WIDTH(8)) u_obuf (
		.mclk      (mclk),
		.arst_n    (arst_n),
		.in_data   (push_data),
		.in_valid  (push_valid),
		.in_ready  (push_ready),
		.out_data  (tx_data),
		.out_valid (tx_valid),
		.out_ready (tx_ready)
	);

	// checks
	property p_delim;
		@(posedge mclk) disable iff (!arst_n) tx_st_q == TX_DELM |-> push_data == DELIM;
	endproperty
	a_delim: assert property (p_delim) else $error("frame not opened by delimiter");

	property p_len_order;
		@(posedge mclk) disable iff (!arst_n) push && tx_st_q == TX_LENH |=> tx_st_q == TX_LENL;
	endproperty
	a_len_order: assert property (p_len_order) else $error("length bytes out of order");

	property p_rsp_type;
		@(posedge mclk) disable iff (!arst_n)
			tx_st_q == TX_BODY && t_pos_q == OFS_TYPE && !kstat_q |-> push_data == FT_LRSP;
	endproperty
	a_rsp_type: assert property (p_rsp_type) else $error("wrong response type");

	property p_stat_type;
		@(posedge mclk) disable iff (!arst_n)
			tx_st_q == TX_BODY && t_pos_q == OFS_TYPE && kstat_q |-> push_data == FT_STAT;
	endproperty
	a_stat_type: assert property (p_stat_type) else $error("wrong status type");

	property p_suppress;
		@(posedge mclk) disable iff (!arst_n) go_rsp && rsp_frame_id == ID_NONE |=> tx_st_q == TX_IDLE;
	endproperty
	a_suppress: assert property (p_suppress) else $error("zero id produced a frame");

	property p_csum;
		@(posedge mclk) disable iff (!arst_n) tx_st_q == TX_CSUM |-> 8'(push_data + t_sum_q) == CSUM_OK;
	endproperty
	a_csum: assert property (p_csum) else $error("bad outgoing checksum");

	property p_drop;
		@(posedge mclk) disable iff (!arst_n)
			rx_take && rx_st_q == RX_CSUM && !rx_good |=> rx_st_q == RX_HUNT && rx_bad_frame;
	endproperty
	a_drop: assert property (p_drop) else $error("bad frame not dropped");

	property p_pwrup;
		@(posedge mclk) disable iff (!arst_n)
			tx_st_q == TX_IDLE && pwrup_q |=> tx_st_q == TX_DELM && kstat_q && t_code_q == STAT_PWRUP;
	endproperty
	a_pwrup: assert property (p_pwrup) else $error("power-up notice missing");

	property p_echo;
		@(posedge mclk) disable iff (!arst_n)
			tx_st_q == TX_BODY && t_pos_q == OFS_ID && !kstat_q |-> push_data == t_id_q;
	endproperty
	a_echo: assert property (p_echo) else $error("id not echoed");

	property p_pending;
		@(posedge mclk) disable iff (!arst_n)
			req_valid && req_ready && rx_rmt && !req_apply && req_name != NAME_APPLY
			&& req_plen != 16'h0000 |=> remote_pending;
	endproperty
	a_pending: assert property (p_pending) else $error("remote write not pending");

	c_rsp:  cover property (@(posedge mclk) disable iff (!arst_n) go_rsp && rsp_frame_id != ID_NONE);
	c_req:  cover property (@(posedge mclk) disable iff (!arst_n) req_valid && req_ready && rx_rmt);
	c_bad:  cover property (@(posedge mclk) disable iff (!arst_n) rx_bad_frame);
	c_full: cover property (@(posedge mclk) disable iff (!arst_n) push_valid && !push_ready);
endmodule : acfc_codec

// ### tb/acfc_host.sv
/*
 * acfc_host: behavioural host processor on the serial byte stream of the codec.
 * Assumes the bench fills send_q with whole frames and reads recv_q; drives at the falling edge.
 */
`timescale 1ns/1ps
module acfc_host (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       arst_n,
	// bytes into the device
	output logic [7:0]      rx_data,
	output logic            rx_valid,
	input  wire logic       rx_ready,
	// bytes out of the device
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_valid,
	output logic            tx_ready
);
	logic [7:0] send_q[$];
	logic [7:0] recv_q[$];
	int         stall_pct = 30;
	bit         taken     = 1'b0;

	initial begin
		rx_data  = 8'h00;
		rx_valid = 1'b0;
		tx_ready = 1'b0;
	end

	// a byte is only counted as sent at an edge where the device was ready
	always @(posedge mclk) begin
		if (arst_n && rx_valid && rx_ready)
			taken = 1'b1;
		if (arst_n && tx_valid && tx_ready)
			recv_q.push_back(tx_data);
	end

	// hold each byte until taken; an idle line toggles so stale data never looks valid
	always @(negedge mclk) begin
		tx_ready <= ($urandom % 100) >= stall_pct; // random stalls exercise the output buffer
		if (!rx_valid || taken) begin
			taken = 1'b0;
			if (send_q.size() > 0) begin
				rx_data  <= send_q.pop_front();
				rx_valid <= 1'b1;
			end else begin
				rx_data  <= ~rx_data;
				rx_valid <= 1'b0;
			end
		end
	end
endmodule : acfc_host

// ### tb/tb_acfc_codec.sv
/*
 * tb_acfc_codec: self-checking bench of the command frame codec with a host model.
 * Assumes the design package is compiled first; expected frames are built here.
 */
`timescale 1ns/1ps
module tb_acfc_codec;
	import acfc_pkg::*;
	typedef logic [7:0] acfc_bytes_type[$];
	logic        mclk, arst_n, rx_valid, rx_ready, tx_valid, tx_ready, req_valid, req_ready, req_remote;
	logic        req_apply, remote_pending, rx_bad_frame, rsp_valid, rsp_ready, stat_valid, stat_ready;
	logic [7:0]  rx_data, tx_data, req_frame_id, param_rdata, rsp_frame_id, rsp_status, stat_code, id, sc;
	logic [15:0] req_name, req_plen, rsp_name, nm;
	logic [63:0] req_addr, rsp_data, ad, dd;
	logic [3:0]  rsp_dlen, param_raddr, dn;
	logic [7:0]  ropt[4]  = '{8'h00, 8'h00, 8'h00, OPT_APPLY};
	logic        rpend[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
	int          errors = 0, total_checks = 0, bad_seen = 0, i, k, pl;
	acfc_bytes_type b, f;

	acfc_host host (.mclk(mclk), .arst_n(arst_n), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
	acfc_codec dut (.mclk(mclk), .arst_n(arst_n), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .req_valid(req_valid),
		.req_ready(req_ready), .req_remote(req_remote), .req_frame_id(req_frame_id), .req_name(req_name),
		.req_addr(req_addr), .req_apply(req_apply), .req_plen(req_plen), .param_raddr(param_raddr),
		.param_rdata(param_rdata), .remote_pending(remote_pending), .rx_bad_frame(rx_bad_frame),
		.rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_frame_id(rsp_frame_id), .rsp_name(rsp_name),
		.rsp_status(rsp_status), .rsp_data(rsp_data), .rsp_dlen(rsp_dlen), .stat_valid(stat_valid),
		.stat_ready(stat_ready), .stat_code(stat_code));

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	// count failure pulses once each, they stand for a single cycle
	always @(posedge mclk) if (rx_bad_frame === 1'b1) bad_seen++;

	task automatic end_of_test;
		$display("errors=%0d total_checks=%0d", errors, total_checks);
		if (errors == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask : chk

	// wraps a body with delimiter, length and checksum
	function automatic acfc_bytes_type frm(input acfc_bytes_type body);
		logic [7:0]  s;
		logic [15:0] n;
		s = 8'h00;
		n = 16'(body.size());
		foreach (body[j]) s += body[j];
		return {DELIM, n[15:8], n[7:0], body, 8'(CSUM_OK - s)};
	endfunction : frm

	function automatic acfc_bytes_type rsp_frame(input logic [7:0] fid, input logic [15:0] name,
			input logic [7:0] st, input logic [63:0] d, input logic [3:0] n);
		acfc_bytes_type body;
		body = {FT_LRSP, fid, name[15:8], name[7:0], st};
		for (int j = 0; j < n; j++) body.push_back(d[63-8*j -: 8]);
		return frm(body);
	endfunction : rsp_frame

	// compares the next bytes seen by the host against a whole frame
	task automatic chk_frame(input acfc_bytes_type e);
		for (int j = 0; j < 3000 && host.recv_q.size() < e.size(); j++) @(negedge mclk);
		if (host.recv_q.size() < e.size())
			chk(64'(host.recv_q.size()), 64'(e.size()));
		else
			foreach (e[j]) chk(64'(host.recv_q.pop_front()), 64'(e[j]));
	endtask : chk_frame

	// waits for a decoded request, checks it, then takes it
	task automatic get_req(input logic rem, input logic [7:0] fid, input logic [15:0] name,
			input logic [63:0] adr, input logic apl, input logic [15:0] n, input logic [7:0] p0);
		for (int j = 0; j < 1000 && req_valid !== 1'b1; j++) @(negedge mclk);
		chk(64'(req_valid), 64'h1);
		chk(64'(rx_ready), 64'h0);
		chk(64'(req_remote), 64'(rem));
		chk(64'(req_frame_id), 64'(fid));
		chk(64'(req_name), 64'(name));
		chk(64'(req_plen), 64'(n));
		if (rem) chk(req_addr, adr);
		if (rem) chk(64'(req_apply), 64'(apl));
		param_raddr = 4'h0;
		@(negedge mclk);
		if (n > 0) chk(64'(param_rdata), 64'(p0));
		req_ready = 1'b1;
		@(negedge mclk);
		req_ready = 1'b0;
	endtask : get_req

	task automatic respond(input logic [7:0] fid, input logic [15:0] name, input logic [7:0] st,
			input logic [63:0] d, input logic [3:0] n);
		@(negedge mclk);
		rsp_valid    = 1'b1;
		rsp_frame_id = fid;
		rsp_name     = name;
		rsp_status   = st;
		rsp_data     = d;
		rsp_dlen     = n;
		for (int j = 0; j < 3000; j++) begin
			@(posedge mclk);
			if (rsp_ready === 1'b1) break;
		end
		@(negedge mclk);
		rsp_valid = 1'b0;
	endtask : respond

	// watchdog: the tests need well under a tenth of this span
	initial begin
		#1_000_000;
		errors++;
		end_of_test();
	end

	initial begin
		void'($urandom(29576));
		{arst_n, req_ready, rsp_valid, stat_valid, param_raddr} = '0;
		{rsp_frame_id, rsp_name, rsp_status, rsp_data, rsp_dlen, stat_code} = '0;
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		arst_n = 1'b1;
		chk_frame('{8'h7E, 8'h00, 8'h02, 8'h8A, 8'h00, 8'h75});
		// local commands of both types, every status code, with and without data
		for (i = 0; i < 6; i++) begin
			id = 8'(1 + $urandom % 255);
			nm = {8'(8'h41 + $urandom % 26), 8'(8'h41 + $urandom % 26)};
			pl = $urandom % 4;
			b  = {((i % 2) ? FT_LCMDQ : FT_LCMD), id, nm[15:8], nm[7:0]};
			for (k = 0; k < pl; k++) b.push_back(8'($urandom));
			host.send_q = {host.send_q, frm(b)};
			get_req(1'b0, id, nm, 64'h0, 1'b0, 16'(pl), (pl > 0) ? b[4] : 8'h00);
			dn = (i == 0) ? 4'h0 : (i == 4) ? 4'h8 : 4'(1 + $urandom % 8);
			dd = {$urandom, $urandom};
			respond(id, nm, 8'(i % 4), dd, dn);
			chk_frame(rsp_frame(id, nm, 8'(i % 4), dd, dn));
		end
		// several frames for one request while the host stalls hard
		host.stall_pct = 90;
		respond(id, nm, ST_OK, dd, 4'h8);
		respond(id, nm, ST_OK, ~dd, 4'h3);
		chk_frame(rsp_frame(id, nm, ST_OK, dd, 4'h8));
		chk_frame(rsp_frame(id, nm, ST_OK, ~dd, 4'h3));
		host.stall_pct = 30;
		// a zero id must not produce any frame
		respond(ID_NONE, nm, ST_OK, dd, 4'h2);
		repeat (40) @(negedge mclk);
		chk(64'(host.recv_q.size()), 64'h0);
		// remote writes: pending without apply, cleared by apply-changes or the apply option
		for (i = 0; i < 4; i++) begin
			id = 8'(1 + $urandom % 255);
			nm = (i == 1) ? NAME_APPLY : 16'h4248;
			ad = {$urandom, $urandom};
			pl = (i == 1) ? 0 : 1;
			b  = {FT_RCMD, id};
			for (k = 0; k < 8; k++) b.push_back(ad[63-8*k -: 8]);
			b = {b, 8'hFF, 8'hFE, ropt[i], nm[15:8], nm[7:0]};
			if (pl > 0) b.push_back(8'($urandom));
			host.send_q = {host.send_q, frm(b)};
			get_req(1'b1, id, nm, ad, ropt[i] == OPT_APPLY, 16'(pl), (pl > 0) ? b[15] : 8'h00);
			chk(64'(remote_pending), 64'(rpend[i]));
		end
		// stray byte, corrupted frame, then a good one: only the good one is decoded
		b = {FT_LCMD, 8'h21, 8'h42, 8'h44, 8'h7E};
		f = frm(b);
		f[f.size()-1] ^= 8'h01;
		host.send_q = {host.send_q, 8'h55, f, frm(b)};
		get_req(1'b0, 8'h21, 16'h4244, 64'h0, 1'b0, 16'h0001, 8'h7E);
		chk(64'(bad_seen), 64'h1);
		// status event with a random code
		sc = 8'($urandom);
		@(negedge mclk);
		stat_code  = sc;
		stat_valid = 1'b1;
		for (k = 0; k < 1000; k++) begin
			@(posedge mclk);
			if (stat_ready === 1'b1) break;
		end
		@(negedge mclk);
		stat_valid = 1'b0;
		chk_frame(frm('{FT_STAT, sc}));
		repeat (20) @(negedge mclk);
		chk(64'(host.recv_q.size()), 64'h0);
		end_of_test();
	end
endmodule : tb_acfc_codec
